// *** soc_pkg.sv ***
// Constants and types shared by the safety output combiner
//
// Operation
// [R01] Two redundant banks; any disagreement faults
// [R02] Positions 1 and 2 select operating mode
// [R03] Invalid mode selection reports code 21
// [R04] Positions 4 and 5 select device count
// [R05] Position 6 picks follow or fault aux
// [R06] Position 7 picks sourcing or sinking aux
// [R07] Outputs on only while selected devices clear
// [R08] Outputs drop within 1 ms of stop
// [R09] Run: green lit, outputs on, start ignored
// [R10] Stop: red lit, outputs and aux off
// [R11] Interlock: yellow, lamp on, press-release exits
// [R12] Lockout blinks; exit by release or reset
// [R13] Red lit except run; outputs off otherwise
// [R14] Aux on in run or lockout by mode
// [R15] Codes 00 normal, 01 waiting, 88 power-up
// [R16] Codes 22 changed, 23 mismatch, 24 hardware
// [R17] Code 25 when start fails to toggle
// [R18] Code 27 for too many devices present
// [R19] Any fault forces lockout, outputs off
// [R20] After power-up show 01 or 00 unless fault
package soc_pkg;

	// ------------------------------------------------------------
	// Sizes and switch positions (bit 0 is position 1, 1 = closed)
	// ------------------------------------------------------------
	localparam int SOC_NUM_DEV   = 4;
	localparam int SOC_SW_W      = 7;
	localparam int SOC_POS_MODE1 = 0;
	localparam int SOC_POS_MODE2 = 1;
	localparam int SOC_POS_CNT4  = 3;
	localparam int SOC_POS_CNT5  = 4;
	localparam int SOC_POS_AUXM  = 5;
	localparam int SOC_POS_AUXT  = 6;

	// ------------------------------------------------------------
	// Display codes, two BCD digits
	// ------------------------------------------------------------
	localparam logic [7:0] SOC_CODE_NORMAL  = 8'h00;
	localparam logic [7:0] SOC_CODE_WAIT    = 8'h01;
	localparam logic [7:0] SOC_CODE_PWRUP   = 8'h88;
	localparam logic [7:0] SOC_CODE_MODE    = 8'h21;
	localparam logic [7:0] SOC_CODE_CHANGED = 8'h22;
	localparam logic [7:0] SOC_CODE_MISMAT  = 8'h23;
	localparam logic [7:0] SOC_CODE_SW_HW   = 8'h24;
	localparam logic [7:0] SOC_CODE_START   = 8'h25;
	localparam logic [7:0] SOC_CODE_EXTRA   = 8'h27;

	// ------------------------------------------------------------
	// Register port map and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] SOC_REG_CTRL    = 4'h0;
	localparam logic [3:0] SOC_REG_STATE   = 4'h1;
	localparam logic [3:0] SOC_REG_CODE    = 4'h2;
	localparam logic [3:0] SOC_REG_CFG     = 4'h3;
	localparam logic [7:0] SOC_CTRL_RST    = 8'h00;
	localparam int         SOC_CTRL_STOP_B = 0;

	// ------------------------------------------------------------
	// Timing, derived at the 4 ns clock
	// ------------------------------------------------------------
	localparam int unsigned SOC_CLK_PERIOD_NS = 4;
	localparam int unsigned SOC_NS_PER_MS     = 1000000;
	localparam int unsigned SOC_CYC_PER_MS    =
		SOC_NS_PER_MS / SOC_CLK_PERIOD_NS;
	localparam int unsigned SOC_PWRUP_MS      = 1000;
	localparam int unsigned SOC_BLINK_HALF_MS = 250;
	localparam int unsigned SOC_STUCK_MS      = 5000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SOC_MODE_AUTO, SOC_MODE_START_IL, SOC_MODE_INVALID,
		SOC_MODE_RESTART_IL
	} soc_mode_e;

	typedef enum logic [2:0] {
		SOC_ST_PWRUP, SOC_ST_STOP, SOC_ST_INTLK, SOC_ST_RUN,
		SOC_ST_LOCK
	} soc_state_e;

	typedef struct packed {
		soc_mode_e  mode;        // Operating mode
		logic [2:0] dev_cnt;     // Selected devices, 1..4
		logic       aux_follow;  // Aux follows run state
		logic       aux_source;  // Aux uses sourcing driver
	} soc_cfg_s;

endpackage

// *** soc_cfg_decode.sv ***
// Decoder for the redundant configuration switch banks
`timescale 1ns/100ps
`default_nettype none
module soc_cfg_decode
	import soc_pkg::*;
(
	input  wire logic [SOC_SW_W-1:0] bank_a,
	input  wire logic [SOC_SW_W-1:0] bank_b,
	output soc_cfg_s                 cfg,
	output logic                     mismatch,
	output logic                     hw_fault
);

	// ------------------------------------------------------------
	// Field decode from bank A
	// ------------------------------------------------------------
	always_comb begin
		// [R02] Mode from positions 1 and 2
		case ({bank_a[SOC_POS_MODE1], bank_a[SOC_POS_MODE2]})
			2'b11:   cfg.mode = SOC_MODE_AUTO;
			2'b10:   cfg.mode = SOC_MODE_START_IL;
			2'b01:   cfg.mode = SOC_MODE_INVALID;
			default: cfg.mode = SOC_MODE_RESTART_IL;
		endcase
		// [R04] Count from positions 4 and 5
		case ({bank_a[SOC_POS_CNT4], bank_a[SOC_POS_CNT5]})
			2'b11:   cfg.dev_cnt = 3'h1;
			2'b10:   cfg.dev_cnt = 3'h2;
			2'b01:   cfg.dev_cnt = 3'h3;
			default: cfg.dev_cnt = 3'h4;
		endcase
		// [R05] Aux mode, closed follows
		cfg.aux_follow = bank_a[SOC_POS_AUXM];
		// [R06] Aux type, closed sources
		cfg.aux_source = bank_a[SOC_POS_AUXT];
	end

	// ------------------------------------------------------------
	// Redundancy checks
	// ------------------------------------------------------------
	// [R01] Any disagreeing position
	assign mismatch = (bank_a != bank_b);
	// [R16] Fully inverted bank taken as hardware fault
	assign hw_fault = (bank_a == ~bank_b);

endmodule
`default_nettype wire

// *** soc_start_mon.sv ***
// Start button watcher: release events and stuck detection
`timescale 1ns/100ps
`default_nettype none
module soc_start_mon
	import soc_pkg::*;
#(
	parameter int unsigned STUCK_CYC = 32'd1
) (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic start_pressed,
	output logic      release_q,
	output logic      stuck_q
);

	logic        held_q;  // Button level last cycle
	logic [31:0] cnt_q;   // Cycles held so far

	// ------------------------------------------------------------
	// Press then release gives one pulse
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			held_q    <= 1'b0;
			release_q <= 1'b0;
		end else begin
			held_q    <= start_pressed;
			release_q <= held_q & ~start_pressed;
		end
	end

	// ------------------------------------------------------------
	// Held too long means it did not toggle
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q   <= 32'h00000000;
			stuck_q <= 1'b0;
		end else if (!start_pressed) begin
			cnt_q   <= 32'h00000000;
			stuck_q <= 1'b0;
		end else if (cnt_q >= STUCK_CYC) begin
			// [R17] Button stuck in pressed position
			stuck_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
		end
	end

endmodule
`default_nettype wire

// *** soc_top.sv ***
// Safety output combiner: state sequencer, outputs and display
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module soc_top
	import soc_pkg::*;
#(
	parameter int unsigned POWERUP_CYC    =
		SOC_PWRUP_MS * SOC_CYC_PER_MS,
	parameter int unsigned BLINK_HALF_CYC =
		SOC_BLINK_HALF_MS * SOC_CYC_PER_MS,
	parameter int unsigned STUCK_CYC      =
		SOC_STUCK_MS * SOC_CYC_PER_MS
) (
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	input  wire logic [SOC_SW_W-1:0]     config_switch_bank_a,
	input  wire logic [SOC_SW_W-1:0]     config_switch_bank_b,
	input  wire logic [SOC_NUM_DEV-1:0]  dev_out_a,
	input  wire logic [SOC_NUM_DEV-1:0]  dev_out_b,
	input  wire logic                    start_pressed,
	input  wire logic [3:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	output logic                         safety_output_a,
	output logic                         safety_output_b,
	output logic                         led_run,
	output logic                         led_stop,
	output logic                         led_interlock,
	output logic                         start_lamp,
	output logic                         aux_out,
	output logic                         aux_source_en,
	output logic                         aux_sink_en,
	output logic      [7:0]              disp_code
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	soc_cfg_s             cfg;          // Decoded switch fields
	logic                 bank_mis;     // Banks disagree
	logic                 bank_hw;      // Bank hardware fault
	logic                 start_rel;    // Press then release pulse
	logic                 start_stuck;  // Start did not toggle
	soc_state_e           state_q;      // Current state
	soc_state_e           state_d;      // Next state
	logic [31:0]          pwr_cnt_q;    // Power-up display timer
	logic [31:0]          blink_cnt_q;  // Blink half-period timer
	logic                 blink_q;      // Blink phase
	logic [SOC_SW_W-1:0]  snap_q;       // Settings seen at start
	logic                 snap_vld_q;   // Snapshot taken
	logic [7:0]           ctrl_q;       // Control register
	logic [7:0]           lock_code_q;  // Code held in lockout
	logic [SOC_NUM_DEV-1:0] chan_ok;    // Device unselected or both outputs on
	logic [SOC_NUM_DEV-1:0] chan_extra; // Unselected device active
	logic                 all_clear;    // Every selected device on, no soft stop
	logic                 extra_dev;    // Too many devices seen
	logic                 changed;      // Settings changed
	logic                 fault_act;    // Any fault present
	logic [7:0]           fault_code;   // Highest priority code
	logic                 soft_stop;    // Software forced stop

	// ------------------------------------------------------------
	// Switch decoder and start watcher
	// ------------------------------------------------------------
	soc_cfg_decode u_cfg (
		.bank_a   (config_switch_bank_a),
		.bank_b   (config_switch_bank_b),
		.cfg      (cfg),
		.mismatch (bank_mis),
		.hw_fault (bank_hw)
	);

	soc_start_mon #(
		.STUCK_CYC (STUCK_CYC)
	) u_start (
		.sys_clk       (sys_clk),
		.resetn        (resetn),
		.start_pressed (start_pressed),
		.release_q     (start_rel),
		.stuck_q       (start_stuck)
	);

	// ------------------------------------------------------------
	// Per device checks
	// ------------------------------------------------------------
	for (genvar i = 0; i < SOC_NUM_DEV; i++) begin : g_dev
		// [R07] Selected device must have both outputs on
		assign chan_ok[i] = (3'(i) >= cfg.dev_cnt) |
			(dev_out_a[i] & dev_out_b[i]);
		// [R18] Active output beyond the selected count
		assign chan_extra[i] = (3'(i) >= cfg.dev_cnt) &
			(dev_out_a[i] | dev_out_b[i]);
	end

	assign soft_stop = ctrl_q[SOC_CTRL_STOP_B];
	// [R07] Combined clear condition
	assign all_clear = (&chan_ok) & ~soft_stop;
	assign extra_dev = |chan_extra;
	// [R16] Settings differ from snapshot
	assign changed   = snap_vld_q &
		(config_switch_bank_a != snap_q);

	// ------------------------------------------------------------
	// Fault priority
	// ------------------------------------------------------------
	always_comb begin
		fault_act  = 1'b1;
		fault_code = SOC_CODE_NORMAL;
		if (bank_hw) begin
			// [R16] Switch hardware fault
			fault_code = SOC_CODE_SW_HW;
		end else if (bank_mis) begin
			// [R01] Banks not redundant
			fault_code = SOC_CODE_MISMAT;
		end else if (changed) begin
			// [R16] Changed while operating
			fault_code = SOC_CODE_CHANGED;
		end else if (cfg.mode == SOC_MODE_INVALID) begin
			// [R03] Invalid mode combination
			fault_code = SOC_CODE_MODE;
		end else if (extra_dev) begin
			// [R18] More devices than selected
			fault_code = SOC_CODE_EXTRA;
		end else if (start_stuck) begin
			// [R17] Start did not toggle
			fault_code = SOC_CODE_START;
		end else begin
			// No fault present
			fault_act = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			SOC_ST_PWRUP: begin
				// Leave after the power-up display time
				if (pwr_cnt_q >= POWERUP_CYC) begin
					if (fault_act) begin
						state_d = SOC_ST_LOCK;
					end else if (cfg.mode == SOC_MODE_AUTO) begin
						state_d = SOC_ST_STOP;
					end else begin
						state_d = SOC_ST_INTLK;
					end
				end
			end
			SOC_ST_RUN: begin
				// [R19] Fault forces lockout
				if (fault_act) begin
					state_d = SOC_ST_LOCK;
				// [R08] Any device stop leaves run at once
				end else if (!all_clear) begin
					state_d = SOC_ST_STOP;
				end
			end
			SOC_ST_STOP: begin
				// [R10] Start ignored while stopped
				if (fault_act) begin
					state_d = SOC_ST_LOCK;
				end else if (all_clear) begin
					if (cfg.mode == SOC_MODE_RESTART_IL) begin
						state_d = SOC_ST_INTLK;
					end else begin
						state_d = SOC_ST_RUN;
					end
				end
			end
			SOC_ST_INTLK: begin
				// [R11] Exit to run only on press and release
				if (fault_act) begin
					state_d = SOC_ST_LOCK;
				end else if (start_rel && all_clear) begin
					state_d = SOC_ST_RUN;
				end
			end
			SOC_ST_LOCK: begin
				// [R12] Fault gone and start released
				if (!fault_act && start_rel) begin
					state_d = SOC_ST_STOP;
				end
			end
			default: begin
				// Recover to the safe state
				state_d = SOC_ST_LOCK;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= SOC_ST_PWRUP;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Power-up display timer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwr_cnt_q <= 32'h00000000;
		end else if (state_q == SOC_ST_PWRUP) begin
			// Count only while showing power-up
			pwr_cnt_q <= pwr_cnt_q + 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// Settings snapshot at end of power-up
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			snap_q     <= '0;
			snap_vld_q <= 1'b0;
		end else if (state_q == SOC_ST_PWRUP &&
			state_d != SOC_ST_PWRUP) begin
			// [R16] Capture reference settings once
			snap_q     <= config_switch_bank_a;
			snap_vld_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Blink generator for lockout
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			blink_cnt_q <= 32'h00000000;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= BLINK_HALF_CYC - 32'd1) begin
			// End of half period, flip phase
			blink_cnt_q <= 32'h00000000;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// Lockout code hold
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lock_code_q <= SOC_CODE_NORMAL;
		end else if (fault_act) begin
			// Keep the latest fault for display
			lock_code_q <= fault_code;
		end
	end

	// ------------------------------------------------------------
	// Safety outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
		end else begin
			// [R09] On in run; [R13] off elsewhere
			// [R07] [R08] Dropped next edge after a stop
			safety_output_a <= (state_q == SOC_ST_RUN) &
				all_clear & ~fault_act;
			safety_output_b <= (state_q == SOC_ST_RUN) &
				all_clear & ~fault_act;
		end
	end

	// ------------------------------------------------------------
	// Indicators and start lamp
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			led_run       <= 1'b0;
			led_stop      <= 1'b1;
			led_interlock <= 1'b0;
			start_lamp    <= 1'b0;
		end else begin
			// [R09] Green only in run
			led_run  <= (state_q == SOC_ST_RUN);
			// [R13] Red in every state but run
			led_stop <= (state_q != SOC_ST_RUN);
			case (state_q)
				SOC_ST_INTLK: begin
					// [R11] Steady yellow and lamp
					led_interlock <= 1'b1;
					start_lamp    <= 1'b1;
				end
				SOC_ST_LOCK: begin
					// [R12] Both blink together
					led_interlock <= blink_q;
					start_lamp    <= blink_q;
				end
				default: begin
					// Dark in other states
					led_interlock <= 1'b0;
					start_lamp    <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Auxiliary output
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			aux_out       <= 1'b0;
			aux_source_en <= 1'b0;
			aux_sink_en   <= 1'b0;
		end else begin
			// [R14] Follow: run only; fault: lockout only
			// [R10] [R11] Off in stop and interlock
			aux_out <= cfg.aux_follow ?
				(state_q == SOC_ST_RUN) :
				(state_q == SOC_ST_LOCK);
			// [R06] Steer to the chosen driver
			aux_source_en <= (cfg.aux_follow ?
				(state_q == SOC_ST_RUN) :
				(state_q == SOC_ST_LOCK)) & cfg.aux_source;
			aux_sink_en <= (cfg.aux_follow ?
				(state_q == SOC_ST_RUN) :
				(state_q == SOC_ST_LOCK)) & ~cfg.aux_source;
		end
	end

	// ------------------------------------------------------------
	// Diagnostic display
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			disp_code <= SOC_CODE_PWRUP;
		end else begin
			case (state_q)
				SOC_ST_PWRUP: begin
					// [R15] Power-up indication
					disp_code <= SOC_CODE_PWRUP;
				end
				SOC_ST_LOCK: begin
					// Live fault, else the one held
					disp_code <= fault_act ? fault_code :
						lock_code_q;
				end
				SOC_ST_INTLK: begin
					// [R20] Waiting for start
					disp_code <= fault_act ? fault_code :
						SOC_CODE_WAIT;
				end
				default: begin
					// [R20] Normal operation
					disp_code <= fault_act ? fault_code :
						SOC_CODE_NORMAL;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register port: control write
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= SOC_CTRL_RST;
		end else if (reg_wr && reg_addr == SOC_REG_CTRL) begin
			// Only the stop bit is kept
			ctrl_q <= {7'h00, reg_wdata[SOC_CTRL_STOP_B]};
		end
	end

	// ------------------------------------------------------------
	// Register port: read data, one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				SOC_REG_CTRL:  reg_rdata <= ctrl_q;
				SOC_REG_STATE: reg_rdata <= {fault_act,
					safety_output_a, 3'h0, state_q};
				SOC_REG_CODE:  reg_rdata <= disp_code;
				SOC_REG_CFG:   reg_rdata <= {1'b0,
					config_switch_bank_a};
				default:       reg_rdata <= 8'h00;
			endcase
		end else begin
			// Data stands one cycle only
			reg_rdata <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// *** soc_top_props.sv ***
// Port checker for the safety output combiner
`timescale 1ns/100ps
`default_nettype none
module soc_top_props
	import soc_pkg::*;
(
	input wire logic                   sys_clk,
	input wire logic                   resetn,
	input wire logic [SOC_SW_W-1:0]    config_switch_bank_a,
	input wire logic [SOC_SW_W-1:0]    config_switch_bank_b,
	input wire logic [SOC_NUM_DEV-1:0] dev_out_a,
	input wire logic [SOC_NUM_DEV-1:0] dev_out_b,
	input wire logic                   safety_output_a,
	input wire logic                   safety_output_b,
	input wire logic                   led_run,
	input wire logic                   led_stop,
	input wire logic                   led_interlock,
	input wire logic                   start_lamp,
	input wire logic                   aux_source_en,
	input wire logic                   aux_sink_en,
	input wire logic [7:0]             disp_code
);
	// ------------------------------------------------------------
	// Clocking and helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Banks differ, but not by full inversion
	wire logic bank_split = config_switch_bank_a != config_switch_bank_b
		&& config_switch_bank_a != ~config_switch_bank_b;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_pair_equal: assert property (
		safety_output_a == safety_output_b) else $error("pair split");
	a_drop_fast: assert property (
		safety_output_a && !(dev_out_a[0] && dev_out_b[0])
		|=> !safety_output_a) else $error("slow drop");
	a_out_green: assert property (
		safety_output_a |-> led_run && !start_lamp)
		else $error("outputs on outside run");
	a_red_not_run: assert property (
		led_run |-> !led_stop && !led_interlock)
		else $error("red or yellow in run");
	a_run_code: assert property (
		safety_output_a |-> disp_code == SOC_CODE_NORMAL)
		else $error("run code wrong");
	a_split_off: assert property (
		config_switch_bank_a != config_switch_bank_b
		|=> !safety_output_a) else $error("run with split banks");
	a_split_code: assert property (
		(bank_split && disp_code != SOC_CODE_PWRUP) [*3]
		|-> disp_code == SOC_CODE_MISMAT) else $error("no code 23");
	a_src_drive: assert property (
		aux_source_en |-> config_switch_bank_a[SOC_POS_AUXT])
		else $error("sourcing driver wrong");
	a_sink_drive: assert property (
		aux_sink_en |-> !config_switch_bank_a[SOC_POS_AUXT])
		else $error("sinking driver wrong");
	// Main scenarios reached
	c_run: cover property (safety_output_a);
	c_blink: cover property ($fell(led_interlock) && !led_stop == 0);
	c_sink: cover property (aux_sink_en);
	c_stuck: cover property (disp_code == SOC_CODE_START);
endmodule
`default_nettype wire

// *** soc_dev_model.sv ***
// Light curtain set feeding the combiner's device inputs
`timescale 1ns/100ps
`default_nettype none
module soc_dev_model
	import soc_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic [SOC_NUM_DEV-1:0] clear,
	input  wire logic                   slow,
	output logic      [SOC_NUM_DEV-1:0] dev_out_a,
	output logic      [SOC_NUM_DEV-1:0] dev_out_b
);
	// Both channels off at power-on
	initial begin
		dev_out_a = 4'h0;
		dev_out_b = 4'h0;
	end
	// Channel A follows the beam; a slow curtain raises B late
	always @(posedge sys_clk) begin
		dev_out_a <= clear;
		dev_out_b <= slow ? (clear & dev_out_a) : clear;
	end
endmodule
`default_nettype wire

// *** soc_top_test.sv ***
// Self-checking bench for the safety output combiner
`timescale 1ns/100ps
`default_nettype none
module soc_top_test;
	import soc_pkg::*;
	logic       sys_clk, resetn, start, reg_wr, reg_rd, slow;
	logic [6:0] bank_a, bank_b, old;
	logic [3:0] clear, reg_addr, da, db;
	logic [7:0] reg_wdata, rdata, disp;
	logic       so_a, so_b, led_run, led_stop, led_il, lamp;
	logic       aux, src, snk, seen;
	int         error_cnt = 0;
	int         cmp_count = 0;
	logic [6:0] tbl_a [4] = '{7'h6A, 7'h69, 7'h6B, 7'h6B};
	logic [6:0] tbl_b [4] = '{7'h6A, 7'h6D, 7'h14, 7'h6B};
	logic [7:0] tbl_c [4] = '{8'h21, 8'h23, 8'h24, 8'h22};
	soc_dev_model u_dev (.sys_clk, .clear, .slow,
		.dev_out_a(da), .dev_out_b(db));
	soc_top #(.POWERUP_CYC(20), .BLINK_HALF_CYC(4), .STUCK_CYC(50)) dut (
		.sys_clk, .resetn, .config_switch_bank_a(bank_a),
		.config_switch_bank_b(bank_b), .dev_out_a(da), .dev_out_b(db),
		.start_pressed(start), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata(rdata), .safety_output_a(so_a), .safety_output_b(so_b),
		.led_run, .led_stop, .led_interlock(led_il), .start_lamp(lamp),
		.aux_out(aux), .aux_source_en(src), .aux_sink_en(snk),
		.disp_code(disp));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Selects the safety output or the display
	function automatic logic [7:0] pick(input bit run);
		return run ? {7'h00, so_a} : disp;
	endfunction
	// Bounded wait; a miss ends the run
	task automatic wait_on(input bit run, input logic [7:0] e);
		for (int i = 0; i < 300 && pick(run) !== e; i++)
			@(negedge sys_clk);
		chk("wait", e, pick(run));
		if (pick(run) !== e)
			close_out();
	endtask
	task automatic do_reset(input logic [6:0] a, b);
		@(posedge sys_clk);
		resetn <= 1'h0;
		bank_a <= a;
		bank_b <= b;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'h1;
	endtask
	task automatic press(input int n);
		@(posedge sys_clk);
		start <= 1'h1;
		repeat (n) @(posedge sys_clk);
		start <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		chk("reg_rdata", e, rdata);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_auto();
		do_reset(7'h6B, 7'h6B);
		clear <= 4'h3;
		@(negedge sys_clk);
		chk("disp", 8'h88, disp);
		chk("led_stop", 1, led_stop);
		rd(SOC_REG_CFG, 8'h6B);
		rd(SOC_REG_CTRL, SOC_CTRL_RST);
		rd(4'hF, 8'h00);
		wait_on(1, 1);
		repeat (3) @(negedge sys_clk);
		chk("aux", 1, aux);
		chk("src", 1, src);
		press(3);
		repeat (5) @(negedge sys_clk);
		chk("so_a", 1, so_a);
		@(posedge sys_clk);
		clear <= 4'h2;
		repeat (4) @(negedge sys_clk);
		chk("so_a", 0, so_a);
		chk("led_stop", 1, led_stop);
		chk("aux", 0, aux);
		clear <= 4'h5;
		wait_on(0, SOC_CODE_EXTRA);
		chk("so_a", 0, so_a);
		clear <= 4'h3;
		press(2);
		wait_on(1, 1);
		wr(SOC_REG_CTRL, 8'h01);
		repeat (2) @(negedge sys_clk);
		chk("so_a", 0, so_a);
		rd(SOC_REG_CTRL, 8'h01);
		rd(SOC_REG_STATE, 8'h01);
		wr(SOC_REG_CTRL, 8'h00);
		wait_on(1, 1);
	endtask
	task automatic t_interlock();
		do_reset(7'h1C, 7'h1C);
		clear <= 4'h1;
		slow <= 1'h1;
		wait_on(0, SOC_CODE_WAIT);
		chk("lamp", 1, lamp);
		chk("led_il", 1, led_il);
		@(posedge sys_clk);
		start <= 1'h1;
		repeat (10) @(negedge sys_clk);
		chk("so_a", 0, so_a);
		@(posedge sys_clk);
		start <= 1'h0;
		wait_on(1, 1);
		chk("lamp", 0, lamp);
		@(posedge sys_clk);
		start <= 1'h1;
		wait_on(0, SOC_CODE_START);
		chk("so_a", 0, so_a);
		repeat (2) @(negedge sys_clk);
		chk("aux", 1, aux);
		chk("snk", 1, snk);
		old = {6'h00, led_il};
		seen = 1'h0;
		repeat (9) begin
			@(negedge sys_clk);
			seen |= (led_il !== old[0]);
		end
		chk("blink", 1, seen);
		@(posedge sys_clk);
		start <= 1'h0;
		repeat (5) @(negedge sys_clk);
		chk("so_a", 0, so_a);
		press(2);
		wait_on(1, 1);
	endtask
	task automatic t_bad_cfg();
		slow <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			clear <= 4'h3;
			do_reset(tbl_a[k], tbl_b[k]);
			if (k == 3) begin
				wait_on(1, 1);
				bank_a <= 7'h4B;
				bank_b <= 7'h4B;
			end
			wait_on(0, tbl_c[k]);
			chk("so_a", 0, so_a);
		end
	endtask
	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		{resetn, start, reg_wr, reg_rd, slow} = 5'h00;
		{bank_a, bank_b, clear, reg_addr} = 22'h000000;
		reg_wdata = 8'h00;
		t_auto();
		t_interlock();
		t_bad_cfg();
		close_out();
	end
endmodule
bind soc_top soc_top_props u_props (.sys_clk, .resetn,
	.config_switch_bank_a, .config_switch_bank_b, .dev_out_a,
	.dev_out_b, .safety_output_a, .safety_output_b, .led_run,
	.led_stop, .led_interlock, .start_lamp, .aux_source_en,
	.aux_sink_en, .disp_code);
`default_nettype wire
